// ### rtl/bcr_engine.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Active flag high while transfer runs, read-only
// [RULE2] Read transfer fills FIFO only as it proceeds
// [RULE3] Full FIFO suspends read transfer, never overwrites
// [RULE4] Resume only when FIFO holds fewer than fourteen
// [RULE5] Raster-op code is the combining function
// [RULE6] Code bits form source/destination truth table
// [RULE7] Pattern fill uses pattern as source operand
// [RULE8] Color expansion: low three bits give start bit
// [RULE9] Operation select field picks transfer kind
// [RULE10] Code 0000: host write with raster-op
// [RULE11] Code 0001: read out through output FIFO
// [RULE12] Code 0010: move, positive address steps
// [RULE13] Code 0011: move, negative address steps
// [RULE14] Code 0100: transparent write skips key color
// [RULE15] Writing start bit one begins the transfer
// [RULE16] Depth bit selects 8 or 16 bit pixels
// [RULE17] Host keeps command fields stable while active
module bcr_engine
  import bcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             addr_step_neg,
  output logic      [1:0]  addr_step_size
);
  import bcr_pkg::*;

  logic [31:0]          cmd_r, cmd_nxt;
  logic [31:0]          ctl_r, ctl_nxt;
  logic [LEN_W-1:0]     len_r, len_nxt;
  logic [PIX_W-1:0]     transp_r, transp_nxt;
  logic [31:0]          opd_r, opd_nxt;
  logic [PIX_W-1:0]     res_r, res_nxt;
  logic [CNT_W-1:0]     used_r, used_nxt;
  logic [CNT_W-1:0]     wptr_r, wptr_nxt;
  logic [CNT_W-1:0]     rptr_r, rptr_nxt;
  logic [PIX_W-1:0]     fifo_r [FIFO_DEPTH];
  logic [PIX_W-1:0]     rd_pix_r, rd_pix_nxt;
  logic [IRQ_W-1:0]     ist_r, ist_nxt;
  logic [IRQ_W-1:0]     imask_r, imask_nxt;
  logic [31:0]          prdata_nxt;
  logic                 pready_nxt;
  logic                 pslverr_nxt;
  logic                 irq_nxt;
  logic                 neg_nxt;
  logic [1:0]           size_nxt;
  bcr_state_t           st_r, st_nxt;

  logic                 acc;
  logic                 wr;
  logic                 rd;
  logic                 hit;
  logic                 push;
  logic                 pop;
  logic [3:0]           kind;
  logic [3:0]           rop;
  logic [PIX_W-1:0]     src;
  logic [PIX_W-1:0]     dst;
  logic [PIX_W-1:0]     rop_out;
  logic [PIX_W-1:0]     kind_res;
  logic [31:0]          status_word;
  logic [PIX_W-1:0]     expand;
  logic [2:0]           start_bit;
  logic                 ev_done;
  logic                 ev_pause;
  logic                 depth16;

  // Slave answers one cycle into the access phase, after one wait state
  assign acc     = psel & penable & ~pready;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign kind    = cmd_r[CMD_KIND_LSB +: FIELD_W];          // [RULE9]
  assign rop     = cmd_r[CMD_ROP_LSB +: FIELD_W];
  assign depth16 = ctl_r[CTL_DEPTH_BIT];                    // [RULE16]
  assign src     = opd_r[PIX_W-1:0];
  assign dst     = opd_r[OPD_DST_LSB +: PIX_W];
  assign start_bit = rop[2:0];                              // [RULE8]

  // Per-bit truth table; for pattern fill src carries the pattern
  always_comb begin
    for (int i = 0; i < PIX_W; i++) begin
      rop_out[i] = rop[{src[i], dst[i]}];                   // [RULE5] [RULE6] [RULE7]
    end
    expand = src[start_bit] ? {PIX_W{1'b1}} : {PIX_W{1'b0}};
  end

  // Read transfer pushes one pixel per cycle, only while running
  assign push = (st_r == ST_RUN) && (kind == KIND_READ)
                && (used_r != FIFO_FULL);                   // [RULE2] [RULE3]
  assign pop  = rd && (paddr == ADDR_FIFO) && (used_r != '0);

  // FIFO bookkeeping; count and pointers move together
  always_comb begin
    wptr_nxt   = wptr_r;
    rptr_nxt   = rptr_r;
    rd_pix_nxt = src;
    if (push) begin
      wptr_nxt = wptr_r + 5'h01;                            // [RULE2]
    end
    if (pop) begin
      rptr_nxt = rptr_r + 5'h01;
    end
    used_nxt = used_r + {4'h0, push} - {4'h0, pop};
  end

  // Result of the current kind; a read transfer keeps the old one
  always_comb begin
    case (kind)
      KIND_WRITE,
      KIND_MOVE_POS,
      KIND_MOVE_NEG,
      KIND_PAT_FILL: begin
        kind_res = rop_out;           // [RULE10] [RULE12] [RULE13]
      end
      KIND_WRITE_TRN: begin
        kind_res = (src == transp_r) ? dst : src;           // [RULE14]
      end
      KIND_COLOR_EXP: begin
        kind_res = expand;                                  // [RULE8]
      end
      default: begin
        kind_res = res_r;                                   // [RULE11]
      end
    endcase
    // Upper byte is dropped so 8-bit results never carry stale bits
    if (!depth16) begin
      kind_res[PIX_W-1:PIX8_W] = '0;                        // [RULE16]
    end
  end

  // Status word as seen by software
  always_comb begin
    status_word                       = '0;
    status_word[ST_ACTIVE_BIT]        = (st_r != ST_IDLE);  // [RULE1]
    status_word[ST_FULL_BIT]          = (used_r == FIFO_FULL);
    status_word[ST_HALF_BIT]          = (used_r >= FIFO_HALF);
    status_word[ST_NEMPTY_BIT]        = (used_r != '0);
    status_word[ST_FREE_LSB +: CNT_W] = FIFO_FULL - used_r;
    status_word[ST_USED_LSB +: CNT_W] = used_r;
  end

  always_comb begin
    st_nxt   = st_r;
    len_nxt  = len_r;
    res_nxt  = res_r;
    ev_done  = 1'b0;
    ev_pause = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // Length is only taken while idle
        if (wr && paddr == ADDR_XFER_LEN) begin
          len_nxt = pwdata[LEN_W-1:0];
        end
        if (wr && paddr == ADDR_CONTROL && pwdata[CTL_START_BIT]) begin
          st_nxt = ST_RUN;                                  // [RULE15]
        end
      end
      ST_RUN: begin
        // A full FIFO stalls the count so no pixel is dropped
        if (kind == KIND_READ && used_r == FIFO_FULL) begin
          if (!pop) begin
            st_nxt   = ST_PAUSE;                            // [RULE3]
            ev_pause = 1'b1;
          end
        end else begin
          res_nxt = kind_res;                               // [RULE5]
          if (len_r <= 16'h0001) begin
            len_nxt = '0;
            st_nxt  = ST_IDLE;
            ev_done = 1'b1;
          end else begin
            len_nxt = len_r - 16'h0001;
          end
        end
      end
      ST_PAUSE: begin
        if (used_r < RESUME_LEVEL) begin
          st_nxt = ST_RUN;                                  // [RULE4]
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    cmd_nxt    = cmd_r;
    ctl_nxt    = ctl_r;
    transp_nxt = transp_r;
    opd_nxt    = opd_r;
    imask_nxt  = imask_r;
    ist_nxt    = ist_r;
    if (wr) begin
      case (paddr)
        // Start bit is write-only and never stored
        ADDR_CONTROL:  ctl_nxt = pwdata & ~(32'h1 << CTL_START_BIT);
        ADDR_COMMAND:  cmd_nxt = pwdata;                    // [RULE17]
        ADDR_TRANSP:   transp_nxt = pwdata[PIX_W-1:0];
        ADDR_OPERANDS: opd_nxt = pwdata;
        ADDR_IRQ_MASK: imask_nxt = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Read clears status, but a same-cycle event still sets
    if (rd && paddr == ADDR_IRQ_STAT) ist_nxt = '0;
    ist_nxt[IRQ_DONE_BIT]  = ist_nxt[IRQ_DONE_BIT] | ev_done;
    ist_nxt[IRQ_PAUSE_BIT] = ist_nxt[IRQ_PAUSE_BIT] | ev_pause;
    irq_nxt  = |(ist_nxt & imask_nxt);
    neg_nxt  = (kind == KIND_MOVE_NEG);                     // [RULE13]
    size_nxt = depth16 ? 2'h2 : 2'h1;                       // [RULE16]
  end

  always_comb begin
    prdata_nxt  = '0;
    pslverr_nxt = 1'b0;
    pready_nxt  = psel & penable & ~pready;
    hit         = 1'b0;
    if (rd) begin
      case (paddr)
        ADDR_CONTROL:  prdata_nxt = ctl_r;
        ADDR_STATUS:   prdata_nxt = status_word;            // [RULE1]
        ADDR_COMMAND:  prdata_nxt = cmd_r;
        ADDR_XFER_LEN: prdata_nxt[LEN_W-1:0] = len_r;
        ADDR_TRANSP:   prdata_nxt[PIX_W-1:0] = transp_r;
        ADDR_OPERANDS: prdata_nxt = opd_r;
        ADDR_RESULT:   prdata_nxt[PIX_W-1:0] = res_r;
        ADDR_FIFO:     prdata_nxt[PIX_W-1:0] = fifo_r[rptr_r[3:0]];
        ADDR_IRQ_STAT: prdata_nxt[IRQ_W-1:0] = ist_r;
        ADDR_IRQ_MASK: prdata_nxt[IRQ_W-1:0] = imask_r;
        default:       pslverr_nxt = 1'b1;
      endcase
    end else if (wr) begin
      // Read-only and unmapped offsets refuse a write
      case (paddr)
        ADDR_CONTROL,
        ADDR_COMMAND,
        ADDR_XFER_LEN,
        ADDR_TRANSP,
        ADDR_OPERANDS,
        ADDR_IRQ_MASK: hit = 1'b1;
        default:       hit = 1'b0;
      endcase
      pslverr_nxt = ~hit;
    end
  end

  // Storage needs no reset; the count says which words are valid
  always_ff @(posedge pclk) begin
    if (push) fifo_r[wptr_r[3:0]] <= rd_pix_r;              // [RULE11]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= ST_IDLE;
      cmd_r          <= CMD_RESET;
      ctl_r          <= CTL_RESET;
      len_r          <= '0;
      transp_r       <= '0;
      opd_r          <= '0;
      res_r          <= '0;
      used_r         <= '0;
      wptr_r         <= '0;
      rptr_r         <= '0;
      rd_pix_r       <= '0;
      ist_r          <= '0;
      imask_r        <= '0;
      prdata         <= '0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      irq            <= 1'b0;
      addr_step_neg  <= 1'b0;
      addr_step_size <= 2'h1;
    end else begin
      st_r           <= st_nxt;
      cmd_r          <= cmd_nxt;
      ctl_r          <= ctl_nxt;
      len_r          <= len_nxt;
      transp_r       <= transp_nxt;
      opd_r          <= opd_nxt;
      res_r          <= res_nxt;
      used_r         <= used_nxt;
      wptr_r         <= wptr_nxt;
      rptr_r         <= rptr_nxt;
      rd_pix_r       <= rd_pix_nxt;
      ist_r          <= ist_nxt;
      imask_r        <= imask_nxt;
      prdata         <= prdata_nxt;
      pready         <= pready_nxt;
      pslverr        <= pslverr_nxt;
      irq            <= irq_nxt;
      addr_step_neg  <= neg_nxt;
      addr_step_size <= size_nxt;
    end
  end

endmodule

// ### rtl/bcr_pkg.sv
package bcr_pkg;

  // Register byte addresses on the APB
  localparam logic [15:0] ADDR_CONTROL  = 16'h8000;
  localparam logic [15:0] ADDR_STATUS   = 16'h8004;
  localparam logic [15:0] ADDR_COMMAND  = 16'h8008;
  localparam logic [15:0] ADDR_XFER_LEN = 16'h8030;
  localparam logic [15:0] ADDR_TRANSP   = 16'h8034;
  localparam logic [15:0] ADDR_OPERANDS = 16'h8038;
  localparam logic [15:0] ADDR_RESULT   = 16'h803c;
  localparam logic [15:0] ADDR_FIFO     = 16'h8040;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h8044;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h8048;

  // Control register fields
  localparam int CTL_START_BIT   = 0;
  localparam int CTL_DEPTH_BIT   = 18;
  // Command register fields
  localparam int CMD_KIND_LSB    = 0;
  localparam int CMD_ROP_LSB     = 16;
  localparam int FIELD_W         = 4;
  // Status register fields
  localparam int ST_ACTIVE_BIT   = 0;
  localparam int ST_FULL_BIT     = 4;
  localparam int ST_HALF_BIT     = 5;
  localparam int ST_NEMPTY_BIT   = 6;
  localparam int ST_FREE_LSB     = 16;
  localparam int ST_USED_LSB     = 24;

  // Operands register: source [15:0], destination [31:16]
  localparam int OPD_DST_LSB     = 16;
  localparam int PIX_W           = 16;
  localparam int PIX8_W          = 8;

  localparam logic [31:0] CMD_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET  = 32'h0000_0000;

  // Output FIFO geometry and restart level
  localparam int          FIFO_DEPTH   = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  FIFO_FULL    = 5'h10;
  localparam logic [4:0]  FIFO_HALF    = 5'h07;
  localparam logic [4:0]  RESUME_LEVEL = 5'h0e;

  localparam int LEN_W = 16;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_PAUSE_BIT = 1;
  localparam int IRQ_W         = 2;

  typedef enum logic [3:0] {
    KIND_WRITE      = 4'h0,
    KIND_READ       = 4'h1,
    KIND_MOVE_POS   = 4'h2,
    KIND_MOVE_NEG   = 4'h3,
    KIND_WRITE_TRN  = 4'h4,
    KIND_PAT_FILL   = 4'h6,
    KIND_COLOR_EXP  = 4'h8
  } bcr_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_PAUSE = 2'b10
  } bcr_state_t;

endpackage

// ### verification/bcr_engine_sva.sv
`timescale 1ns/1ps
module bcr_engine_sva
  import bcr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        addr_step_neg,
  input wire logic [1:0]  addr_step_size
);
  logic cmd_w;
  assign cmd_w = psel && pwrite && paddr == ADDR_COMMAND;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access edge of a write
  sequence wr_s(logic [15:0] a);
    psel && penable && pwrite && !pready && paddr == a;
  endsequence
  acc_wait_a: assert property (
    $rose(penable) && psel |=> pready) else $error("pready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready held");
  neg_set_a: assert property (
    wr_s(ADDR_COMMAND) ##0 pwdata[3:0] == 4'h3 |-> ##[1:3] addr_step_neg)
    else $error("no negative step");
  neg_clr_a: assert property (
    wr_s(ADDR_COMMAND) ##0 pwdata[3:0] != 4'h3 |-> ##[1:3] !addr_step_neg)
    else $error("negative step stuck");
  step_wide_a: assert property (
    wr_s(ADDR_CONTROL) ##0 pwdata[CTL_DEPTH_BIT]
    |-> ##[1:3] addr_step_size == 2'd2) else $error("step not 2");
  step_narrow_a: assert property (
    wr_s(ADDR_CONTROL) ##0 !pwdata[CTL_DEPTH_BIT]
    |-> ##[1:3] addr_step_size == 2'd1) else $error("step not 1");
  mask_off_a: assert property (
    wr_s(ADDR_IRQ_MASK) ##0 pwdata[1:0] == 2'b00 |-> ##[1:3] !irq)
    else $error("masked irq high");
  neg_hold_a: assert property (
    $changed(addr_step_neg) |-> cmd_w || $past(cmd_w))
    else $error("step sign moved alone");
endmodule
bind bcr_engine bcr_engine_sva chk_u (
  .pclk           (pclk),
  .presetn        (presetn),
  .psel           (psel),
  .penable        (penable),
  .pwrite         (pwrite),
  .paddr          (paddr),
  .pwdata         (pwdata),
  .prdata         (prdata),
  .pready         (pready),
  .pslverr        (pslverr),
  .irq            (irq),
  .addr_step_neg  (addr_step_neg),
  .addr_step_size (addr_step_size)
);

// ### verification/bcr_host_model.sv
`timescale 1ns/1ps
module bcr_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [15:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata_q;
  logic        err_q;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // No wait count assumed: the request stands until pready
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata_q = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show junk so stale values cannot pass
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ### verification/blit_command_rop_decode_tb_top.sv
`timescale 1ns/1ps
module blit_command_rop_decode_tb_top;
  import bcr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        addr_step_neg, depth;
  logic [1:0]  addr_step_size;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          miscompares, checks_done, cycles;
  bcr_engine dut_u (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .irq            (irq),
    .addr_step_neg  (addr_step_neg),
    .addr_step_size (addr_step_size)
  );
  bcr_host_model host_u (
    .pclk    (pclk),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Run needs a few thousand cycles; ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (checks_done > 0 && miscompares == 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    host_u.xfer(1'b0, a, 32'h0);
    q = host_u.rdata_q;
  endtask
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS);
      n++;
    end while (q[b] !== v && n < 300);
    chk("wait_bit", {31'h0, v}, {31'h0, q[b]});
  endtask
  task automatic start();
    wr(ADDR_CONTROL, {13'h0, depth, 18'h1});
  endtask
  task automatic run(input logic [3:0] k, r, input logic [15:0] s, d);
    wr(ADDR_OPERANDS, {d, s});
    wr(ADDR_COMMAND, {12'h0, r, 12'h0, k});
    start();
    wait_bit(ST_ACTIVE_BIT, 1'b0);
    rd(ADDR_RESULT);
  endtask
  task automatic t_basic();
    chk("step_size", 32'h1, {30'h0, addr_step_size});
    rd(ADDR_COMMAND);
    chk("command", CMD_RESET, q);
    rd(16'h8100);
    chk("slverr", 32'h1, {31'h0, host_u.err_q});
  endtask
  task automatic t_rop();
    logic [3:0]  kd [4] = '{4'h0, 4'h2, 4'h3, 4'h6};
    logic [15:0] e;
    for (int r = 0; r < 16; r++) begin
      foreach (kd[i]) begin
        run(kd[i], r[3:0], 16'hcccc, 16'haaaa);
        chk("rop", {16'h0, {4{r[3:0]}}}, q);
        chk("neg", {31'h0, kd[i] == 4'h3}, {31'h0, addr_step_neg});
      end
      run(4'h8, r[3:0], 16'h00a5, 16'h0);
      e = 16'h00a5 >> r[2:0];
      chk("cexp", e[0] ? 32'hffff : 32'h0, q);
    end
    chk("size16", 32'h2, {30'h0, addr_step_size});
  endtask
  task automatic t_depth();
    depth = 1'b0;
    wr(ADDR_TRANSP, 32'h55);
    run(4'h4, 4'hc, 16'h0055, 16'h0f0f);
    chk("transp", 32'h000f, q);
    run(4'h0, 4'h6, 16'hcccc, 16'haaaa);
    chk("rop8", 32'h0066, q);
    chk("size8", 32'h1, {30'h0, addr_step_size});
    depth = 1'b1;
  endtask
  task automatic t_active();
    wr(ADDR_IRQ_MASK, 32'h3);
    rd(ADDR_IRQ_STAT);
    wr(ADDR_XFER_LEN, 32'h40);
    start();
    rd(ADDR_STATUS);
    chk("busy", 32'h1, {31'h0, q[0]});
    wait_bit(ST_ACTIVE_BIT, 1'b0);
    chk("idle", 32'h0, {31'h0, q[0]});
    chk("irq_set", 32'h1, {31'h0, irq});
    rd(ADDR_IRQ_STAT);
    chk("irq_done", 32'h1, q & 32'h1);
    rd(ADDR_STATUS);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_XFER_LEN, 32'h0);
    start();
    wait_bit(ST_ACTIVE_BIT, 1'b0);
    chk("irq_mask", 32'h0, {31'h0, irq});
  endtask
  task automatic t_read();
    wr(ADDR_XFER_LEN, 32'h14);
    wr(ADDR_OPERANDS, 32'h1234);
    wr(ADDR_COMMAND, 32'h1);
    start();
    wait_bit(ST_FULL_BIT, 1'b1);
    chk("full", 32'h1000_0011, q & 32'h1f00_0011);
    for (int i = 0; i < 32'h14; i++) begin
      rd(ADDR_FIFO);
      chk("pop", 32'h1234, q & 32'hffff);
      if (i == 1) begin
        rd(ADDR_STATUS);
        rd(ADDR_STATUS);
        chk("hold14", 32'he, {27'h0, q[28:24]});
      end
      if (i == 2) begin
        wait_bit(ST_FULL_BIT, 1'b1);
        chk("resume", 32'h10, {27'h0, q[28:24]});
      end
    end
    rd(ADDR_STATUS);
    chk("drained", 32'h0, q & 32'h1f00_0001);
    rd(ADDR_IRQ_STAT);
    chk("irq_pause", 32'h2, q & 32'h2);
  endtask
  initial begin
    presetn = 1'b0;
    depth = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_basic();
    t_rop();
    t_depth();
    t_active();
    t_read();
    summarize();
  end
endmodule
